// ==== logic/mdfs_pkg.sv ====
// constants, types and helpers for the motor driver fault and sleep controller
package mdfs_pkg;

  // clock and counter sizing
  localparam int CLK_MHZ = 250;
  localparam int CNT_W   = 20;

  // sleep pin clearing pulse window, in ns
  localparam int PULSE_MIN_NS   = 20000;
  localparam int PULSE_MAX_NS   = 40000;
  localparam int PULSE_LIMIT_NS = 120000;

  // default delays, in ns; they are top parameters so a bench can shorten them
  localparam int OCP_FILTER_NS_DEF  = 1000;
  localparam int SLEEP_ENTRY_NS_DEF = 100000;
  localparam int WAKE_NS_DEF        = 1000000;

  // order of the pins inside the synchroniser bundle
  localparam int PIN_W       = 5;
  localparam int PIN_SLEEP   = 0;
  localparam int PIN_SUPPLY  = 1;
  localparam int PIN_PUMP    = 2;
  localparam int PIN_OVC     = 3;
  localparam int PIN_THERMAL = 4;

  // register map, byte addresses
  localparam int                ADDR_W     = 4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h4;

  // status word fields
  localparam int STAT_SUPPLY_BIT = 0;
  localparam int STAT_PUMP_BIT   = 1;
  localparam int STAT_OCP_BIT    = 2;
  localparam int STAT_THERM_BIT  = 3;
  localparam int STAT_SLEEP_BIT  = 4;
  localparam int STAT_READY_BIT  = 5;
  localparam int STAT_PIN_BIT    = 6;
  localparam int STAT_STATE_LSB  = 8;

  // control word fields and reset value
  localparam int   CTRL_CLEAR_BIT   = 0;
  localparam int   CTRL_INHIBIT_BIT = 1;
  localparam logic CTRL_INHIBIT_RST = 1'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // power states, gray coded along sleep, wake, active, lockout
  typedef enum logic [1:0] {
    ST_SLEEP   = 2'h0,
    ST_WAKE    = 2'h1,
    ST_ACTIVE  = 2'h3,
    ST_LOCKOUT = 2'h2
  } mdfs_state_t;

  // least time in ns to whole clock cycles, rounded up, never below one
  function automatic int cyc_at_least(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

// ==== logic/mdfs_pin_if.sv ====
// bundle of qualified pin levels passed from the synchroniser to the controller
`timescale 1ns/1ps
interface mdfs_pin_if #(
  parameter int W = 5
);
  logic [W-1:0] level;

  modport src (output level);
  modport snk (input level);
endinterface

// ==== logic/mdfs_pin_sync.sv ====
// three-stage pin synchroniser; a level counts once stages two and three agree
`timescale 1ns/1ps
module mdfs_pin_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  logic          aclk,
  input  logic          aresetn,
  // raw asynchronous pins
  input  logic [W-1:0]  raw,
  // qualified levels
  mdfs_pin_if.src       pins
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } mdfs_sync_t;

  mdfs_sync_t q;
  mdfs_sync_t d;

  if (W < 1) begin : g_chk
    $error("mdfs_pin_sync: W must be at least 1");
  end

  // shift chain; only stage two reads stage one, so metastability stays contained
  always_comb begin
    d     = q;
    d.s1  = raw;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);
  end

  // pins reset to low, which reads as asleep and fault free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins.level = q.lvl;

endmodule

// ==== logic/mdfs_ctrl.sv ====
// fault supervision and power state control for one h-bridge, with an axi4-lite port
//
// Summary of operation
// [RQ1] supply lockout turns off the bridge and the charge pump and pulls the fault pin low.
// [RQ2] when the supply recovers the bridge resumes and the fault pin releases by itself.
// [RQ3] pump rail undervoltage turns off the bridge and pulls the fault pin low, pump kept on; the code flags it only in ST_ACTIVE, not during wake.
// [RQ4] clearing of the pump rail undervoltage restores operation with no outside action.
// [RQ5] a current limit lasting past the filter time disables the bridge and flags a fault.
// [RQ6] an overcurrent fault stays latched until a clearing pulse or a power cycle; the code also clears it on a write of the control clear bit.
// [RQ7] overtemperature disables all bridge transistors and flags a fault.
// [RQ8] a thermal fault stays latched until cool and then cleared by pulse or power cycle; the code also clears it, once cool, by a control clear bit write.
// [RQ9] the sleep pin held low for the entry delay puts the device to sleep, pump off.
// [RQ10] raising the sleep pin wakes the device; inputs are accepted after the wake delay.
// [RQ11] active mode requires the sleep pin high and the supply above lockout.
// [RQ12] a low pulse longer than 20 us and shorter than 40 us clears all latched faults.
// [RQ13] a low pulse of 40 us to 120 us also clears latches; sleep may or may not follow.
// [RQ14] a clearing pulse leaves the charge pump and the other blocks as they were.
// [RQ15] the open-drain fault pin is released after power-up and pulled low on any fault.
// [RQ16] the fault pin is the or of all live and latched faults; delays are parameters.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module mdfs_ctrl
  import mdfs_pkg::*;
#(
  parameter int OCP_FILTER_NS  = OCP_FILTER_NS_DEF,
  parameter int SLEEP_ENTRY_NS = SLEEP_ENTRY_NS_DEF,
  parameter int WAKE_NS        = WAKE_NS_DEF,
  parameter int CLEAR_MIN_NS   = PULSE_MIN_NS
) (
  // clock and reset
  input  logic              aclk,
  input  logic              aresetn,
  // device pins and analog comparator levels
  input  logic              sleep_control_pin,
  input  logic              supply_lockout,
  input  logic              pump_rail_undervoltage,
  input  logic              overcurrent_trip,
  input  logic              thermal_shutdown,
  // power stage controls
  output logic              bridge_enable,
  output logic              charge_pump_enable,
  output logic              device_ready,
  // open-drain fault pin
  output logic              fault_indicator_out_o,
  output logic              fault_indicator_out_oe_n,
  // axi4-lite write address and data
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic [2:0]        s_axi_awprot,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  // axi4-lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  // axi4-lite read
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic [2:0]        s_axi_arprot,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready
);

  // cycle counts derived from the delay parameters
  localparam int CLR_CYC   = cyc_at_least(CLEAR_MIN_NS);
  localparam int SLEEP_CYC = cyc_at_least(SLEEP_ENTRY_NS);
  localparam int WAKE_CYC  = cyc_at_least(WAKE_NS);
  localparam int OCP_CYC   = cyc_at_least(OCP_FILTER_NS);
  localparam logic [CNT_W-1:0] CLR_CNT   = CNT_W'(CLR_CYC);
  localparam logic [CNT_W-1:0] SLEEP_CNT = CNT_W'(SLEEP_CYC);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] OCP_LAST  = CNT_W'(OCP_CYC - 1);

  // the clearing pulse must end before sleep entry, and every count must fit
  if (SLEEP_ENTRY_NS < PULSE_MAX_NS || SLEEP_ENTRY_NS > PULSE_LIMIT_NS ||
      CLEAR_MIN_NS >= PULSE_MAX_NS || WAKE_CYC >= (1 << CNT_W) ||
      OCP_CYC >= (1 << CNT_W)) begin : g_chk
    $error("mdfs_ctrl: delay parameters out of range");
  end

  typedef struct packed {
    mdfs_state_t       st;
    logic [CNT_W-1:0]  low_cnt;
    logic [CNT_W-1:0]  wake_cnt;
    logic [CNT_W-1:0]  ocp_cnt;
    logic              ocp_lat;
    logic              therm_lat;
    logic              inhibit;
    logic              bridge_en;
    logic              pump_en;
    logic              fault_oe_n;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } mdfs_ctrl_t;

  mdfs_ctrl_t q;
  mdfs_ctrl_t d;

  // qualified pins
  mdfs_pin_if #(.W(PIN_W)) pins_if ();

  mdfs_pin_sync #(.W(PIN_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     ({thermal_shutdown, overcurrent_trip, pump_rail_undervoltage,
                supply_lockout, sleep_control_pin}),
    .pins    (pins_if.src)
  );

  logic pin_hi;
  logic sup_low;
  logic pump_low;
  logic ovc_on;
  logic hot;
  logic pulse_clear;
  logic sw_clear;
  logic sleep_go;
  logic pump_flt;
  logic clear_all;
  logic [31:0] status_word;

  assign pin_hi   = pins_if.level[PIN_SLEEP];
  assign sup_low  = pins_if.level[PIN_SUPPLY];
  assign pump_low = pins_if.level[PIN_PUMP];
  assign ovc_on   = pins_if.level[PIN_OVC];
  assign hot      = pins_if.level[PIN_THERMAL];

  // register decode shared by the write and read paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == REG_STATUS) begin
      return 2'h1;
    end else if (a == REG_CTRL) begin
      return 2'h2;
    end else begin
      return 2'h0;
    end
  endfunction

  // status word as software sees it
  always_comb begin
    status_word                                  = '0;
    status_word[STAT_SUPPLY_BIT]                 = sup_low;
    status_word[STAT_PUMP_BIT]                   = pump_low;
    status_word[STAT_OCP_BIT]                    = q.ocp_lat;
    status_word[STAT_THERM_BIT]                  = q.therm_lat;
    status_word[STAT_SLEEP_BIT]                  = (q.st == ST_SLEEP);
    status_word[STAT_READY_BIT]                  = (q.st == ST_ACTIVE);
    status_word[STAT_PIN_BIT]                    = pin_hi;
    status_word[STAT_STATE_LSB+1:STAT_STATE_LSB] = q.st;
  end

  // handshake readies come straight from the held flags
  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready  = !q.w_held && !q.bvalid;
  assign s_axi_arready = !q.rvalid;

  // next-state logic for bus, timers, fault latches and power stage
  always_comb begin
    d           = q;
    sw_clear    = 1'b0;
    // bus write: address and data taken in either order, then one response
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_held = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_held = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (reg_sel(q.awaddr) == 2'h2) begin
        if (q.wstrb[0]) begin
          d.inhibit = q.wdata[CTRL_INHIBIT_BIT];
          sw_clear  = q.wdata[CTRL_CLEAR_BIT];
        end
      end else if (reg_sel(q.awaddr) == 2'h0) begin
        d.bresp = RESP_SLVERR;
      end
    end
    // bus read: unmapped addresses read zero with an error response
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      if (reg_sel(s_axi_araddr) == 2'h1) begin
        d.rdata = status_word;
      end else if (reg_sel(s_axi_araddr) == 2'h2) begin
        d.rdata[CTRL_INHIBIT_BIT] = q.inhibit;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    // how long the sleep pin has been low, saturating
    if (pin_hi) begin
      d.low_cnt = '0;
    end else if (q.low_cnt != '1) begin
      d.low_cnt = q.low_cnt + 1'b1;
    end
    pulse_clear = !pin_hi && (q.low_cnt == CLR_CNT); // [RQ12] [RQ13]
    sleep_go    = !pin_hi && (q.low_cnt == SLEEP_CNT); // [RQ9]
    // supply lockout clears the fault latches, which acts as a power cycle
    clear_all   = pulse_clear || sw_clear || sup_low; // [RQ6] [RQ8]
    // pump rail is only judged once the device is awake and the pump has settled
    pump_flt    = pump_low && (q.st == ST_ACTIVE); // [RQ3]
    // power state machine
    case (q.st)
      ST_SLEEP: begin
        if (sup_low) begin
          d.st = ST_LOCKOUT;
        end else if (pin_hi) begin
          d.st       = ST_WAKE; // [RQ10]
          d.wake_cnt = '0;
        end
      end
      ST_WAKE: begin
        if (sup_low) begin
          d.st = ST_LOCKOUT;
        end else if (sleep_go) begin
          d.st = ST_SLEEP;
        end else if (q.wake_cnt == WAKE_LAST && pin_hi) begin
          d.st = ST_ACTIVE; // [RQ10] [RQ11]
        end else if (q.wake_cnt != WAKE_LAST) begin
          d.wake_cnt = q.wake_cnt + 1'b1;
        end
      end
      ST_ACTIVE: begin
        // a short clearing pulse does not leave this state
        if (sup_low) begin
          d.st = ST_LOCKOUT; // [RQ1] [RQ11]
        end else if (sleep_go) begin
          d.st = ST_SLEEP; // [RQ9]
        end
      end
      ST_LOCKOUT: begin
        if (!sup_low) begin
          d.st       = pin_hi ? ST_WAKE : ST_SLEEP; // [RQ2]
          d.wake_cnt = '0;
        end
      end
      default: begin
        d.st = ST_SLEEP;
      end
    endcase
    // overcurrent filter counts consecutive cycles of current limit while driving
    if (ovc_on && q.bridge_en) begin
      if (q.ocp_cnt != '1) begin
        d.ocp_cnt = q.ocp_cnt + 1'b1;
      end
    end else begin
      d.ocp_cnt = '0;
    end
    // latches: a thermal fault or a completed overcurrent filter in the clearing cycle wins over the clear
    d.ocp_lat   = (ovc_on && q.bridge_en && q.ocp_cnt == OCP_LAST) ||
                  (q.ocp_lat && !clear_all); // [RQ5] [RQ6]
    d.therm_lat = hot || (q.therm_lat && !clear_all); // [RQ7] [RQ8]
    // power stage outputs follow the next state, so they lag the pins by one edge
    d.bridge_en  = (d.st == ST_ACTIVE) && !pump_flt && !d.ocp_lat &&
                   !d.therm_lat && !d.inhibit; // [RQ1] [RQ3] [RQ4] [RQ5] [RQ7] [RQ11]
    d.pump_en    = (d.st == ST_WAKE || d.st == ST_ACTIVE) && !d.therm_lat; // [RQ1] [RQ3] [RQ14]
    d.fault_oe_n = !(sup_low || pump_flt || d.ocp_lat || d.therm_lat); // [RQ15] [RQ16]
  end

  // single state register; fault pin released from reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.st         <= ST_SLEEP;
      q.inhibit    <= CTRL_INHIBIT_RST;
      q.fault_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign bridge_enable            = q.bridge_en;
  assign charge_pump_enable       = q.pump_en;
  assign device_ready             = (q.st == ST_ACTIVE);
  assign fault_indicator_out_o    = 1'b0; // open drain only ever pulls low
  assign fault_indicator_out_oe_n = q.fault_oe_n;
  assign s_axi_bvalid             = q.bvalid;
  assign s_axi_bresp              = q.bresp;
  assign s_axi_rvalid             = q.rvalid;
  assign s_axi_rresp              = q.rresp;
  assign s_axi_rdata              = q.rdata;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_lockout_off: assert property (sup_low |=> !q.bridge_en && !q.pump_en && !q.fault_oe_n) // [RQ1]
    else $error("lockout did not shut the stage down");
  a_lockout_release: assert property ($fell(sup_low) && !hot && !$past(hot) |=> // [RQ2]
      q.fault_oe_n)
    else $error("fault pin not released after lockout");
  // lockout or sleep entry in the same cycle legitimately stop the pump
  a_pump_uv_hold: assert property (pump_flt && !hot && !q.therm_lat && !sup_low && // [RQ3]
      !sleep_go |=> !q.bridge_en && q.pump_en && !q.fault_oe_n)
    else $error("pump rail fault handled wrongly");
  a_ocp_filter: assert property ($rose(q.ocp_lat) |-> // [RQ5]
      $past(q.ocp_cnt) == OCP_LAST && $past(ovc_on))
    else $error("overcurrent latched at the wrong count");
  a_ocp_sticky: assert property (q.ocp_lat && !clear_all |=> q.ocp_lat && !q.bridge_en) // [RQ6]
    else $error("overcurrent latch lost without clear");
  a_therm_sticky: assert property (q.therm_lat && hot |=> q.therm_lat && !q.pump_en) // [RQ8]
    else $error("thermal latch cleared while hot");
  a_sleep_entry: assert property (q.st == ST_ACTIVE ##1 q.st == ST_SLEEP |-> // [RQ9]
      $past(q.low_cnt) == SLEEP_CNT)
    else $error("sleep entered before the entry delay");
  a_wake_delay: assert property (q.st == ST_WAKE ##1 q.st == ST_ACTIVE |-> // [RQ10]
      $past(q.wake_cnt) == WAKE_LAST)
    else $error("ready before the wake delay");
  a_active_cond: assert property ($rose(q.st == ST_ACTIVE) |-> // [RQ11]
      $past(pin_hi) && !$past(sup_low))
    else $error("active without pin high and supply good");
  a_pulse_clears: assert property (pulse_clear && !hot && !sw_clear |=> !q.therm_lat) // [RQ12]
    else $error("clearing pulse left thermal latch set");
  a_pulse_keeps: assert property (q.st == ST_ACTIVE && !sup_low && !pin_hi && // [RQ14]
      q.low_cnt < CLR_CNT |=> q.st == ST_ACTIVE)
    else $error("short pulse disturbed the active state");
  a_fault_or: assert property (q.ocp_lat || q.therm_lat |-> !q.fault_oe_n) // [RQ16]
    else $error("latched fault not shown on the fault pin");

  c_pulse_clear: cover property (pulse_clear && q.ocp_lat);
  c_sleep_entry: cover property (q.st == ST_ACTIVE ##1 q.st == ST_SLEEP);
  c_wake_done: cover property (q.st == ST_WAKE ##1 q.st == ST_ACTIVE);
  c_ocp_trip: cover property ($rose(q.ocp_lat));

endmodule

// ==== sim/mdfs_ctrl_partner.sv ====
// controller model: drives the sleep pin and reads the open-drain fault line
`timescale 1ns/1ps
module mdfs_ctrl_partner #(
  parameter int WAKE_CYC = 500
) (
  // clock
  input  wire logic        aclk,
  // requests from the bench
  input  wire logic        run_req,
  input  wire logic        clear_req,
  input  wire logic [15:0] clear_len,
  // device fault pin, split into data and enable
  input  wire logic        fault_o,
  input  wire logic        fault_oe_n,
  // what the controller sees and drives
  output logic             sleep_control_pin,
  output logic             fault_n,
  output logic             pulsing,
  output logic             inputs_ok
);
  logic [15:0] low_cnt_q  = 16'h0000;
  logic [19:0] wake_cnt_q = 20'h00000;

  // board pull-up: a released line reads high, never the last driven level
  assign fault_n = fault_oe_n ? 1'b1 : fault_o;
  assign pulsing = (low_cnt_q != 16'h0000);
  // a clearing pulse overrides the run level for an exact number of cycles
  assign sleep_control_pin = run_req && !pulsing;
  always_ff @(posedge aclk) begin
    if (clear_req) begin
      low_cnt_q <= clear_len;
    end else if (pulsing) begin
      low_cnt_q <= low_cnt_q - 16'h0001;
    end
  end
  // bridge inputs are held back until the wake delay has passed
  always_ff @(posedge aclk) begin
    if (!sleep_control_pin) begin
      wake_cnt_q <= 20'h00000;
    end else if (!inputs_ok) begin
      wake_cnt_q <= wake_cnt_q + 20'h00001;
    end
  end
  assign inputs_ok = (wake_cnt_q >= 20'(WAKE_CYC));
endmodule

// ==== sim/tb_motor_driver_fault_sleep_ctrl.sv ====
// self-checking bench for the fault and sleep controller
`timescale 1ns/1ps
module tb_motor_driver_fault_sleep_ctrl;
  import mdfs_pkg::*;
  localparam int WK = 2000 * CLK_MHZ / 1000;  // wake delay in cycles
  localparam int SL = 40000 * CLK_MHZ / 1000; // sleep entry delay in cycles
  logic              aclk, aresetn, run_req, clear_req, sup_lo, pump_uv, ovc, hot, held;
  logic [15:0]       clear_len, lfsr_q;
  logic              bridge_enable, charge_pump_enable, device_ready;
  logic              f_o, f_oe_n, sleep_pin, fault_n, pulsing, inputs_ok;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp;
  logic [2:0]        prot;
  logic [3:0]        wstrb;
  int                fail_count, n_tests, n;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  mdfs_ctrl #(.OCP_FILTER_NS(40), .SLEEP_ENTRY_NS(40000), .WAKE_NS(2000),
    .CLEAR_MIN_NS(200)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .sleep_control_pin(sleep_pin),
    .supply_lockout(sup_lo), .pump_rail_undervoltage(pump_uv),
    .overcurrent_trip(ovc), .thermal_shutdown(hot),
    .bridge_enable(bridge_enable), .charge_pump_enable(charge_pump_enable),
    .device_ready(device_ready), .fault_indicator_out_o(f_o),
    .fault_indicator_out_oe_n(f_oe_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  mdfs_ctrl_partner #(.WAKE_CYC(WK)) i_partner (
    .aclk(aclk), .run_req(run_req), .clear_req(clear_req), .clear_len(clear_len),
    .fault_o(f_o), .fault_oe_n(f_oe_n), .sleep_control_pin(sleep_pin),
    .fault_n(fault_n), .pulsing(pulsing), .inputs_ok(inputs_ok));

  // pseudo-random source, fixed start so runs repeat
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // status word expected with no fault present
  function automatic logic [31:0] exp_status(input logic rdy, input logic pin,
                                             input mdfs_state_t st);
    logic [31:0] w;
    w = 32'h0;
    w[STAT_READY_BIT] = rdy;
    w[STAT_PIN_BIT] = pin;
    w[STAT_STATE_LSB +: 2] = st;
    return w;
  endfunction

  function automatic logic cur(input int w);
    case (w)
      0: return device_ready;
      1: return bridge_enable;
      2: return charge_pump_enable;
      default: return fault_n;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for one output to reach a level; n counts the edges
  task automatic wait_for(input int w, input logic v, input int lim, output int k);
    k = 0;
    while (cur(w) !== v) begin
      @(posedge aclk);
      k++;
      if (k > lim) begin
        fail_count++;
        $display("mismatch at %0t: wait %0d got %h expected %h", $time, w, cur(w), v);
        report_and_stop();
      end
    end
  endtask

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           input logic [1:0] r);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk(bresp, r);
        bready <= 1'b0;
      end
    end while (!(bready && bvalid) && k < 50);
    if (k >= 50) begin
      fail_count++;
      report_and_stop();
    end
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                          input logic [1:0] r);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rdata, d);
        chk(rresp, r);
        rready <= 1'b0;
      end
    end while (!(rready && rvalid) && k < 50);
    if (k >= 50) begin
      fail_count++;
      report_and_stop();
    end
    @(posedge aclk);
  endtask

  // clearing pulse; watches that pump and ready hold while it runs
  task automatic clear_pulse(input int w, output logic ok);
    int k;
    ok = 1'b1;
    k = 0;
    clear_len <= 16'(w);
    clear_req <= 1'b1;
    @(posedge aclk);
    clear_req <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
      if (charge_pump_enable !== 1'b1 || device_ready !== 1'b1) ok = 1'b0;
    end while (pulsing && k < 10000);
    if (pulsing) begin
      chk(32'h1, 32'h0);
      report_and_stop();
    end
    repeat (8) @(posedge aclk); // pin synchroniser lag
  endtask

  initial begin
    {aresetn, run_req, clear_req, sup_lo, pump_uv, ovc, hot} = 7'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    clear_len = 16'h0000;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    prot = 3'h0;
    wstrb = 4'hF;
    lfsr_q = 16'h0036;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(fault_n, 1'b1);
    chk(charge_pump_enable, 1'b0);
    // wake from sleep: ready only after the wake delay
    run_req <= 1'b1;
    wait_for(0, 1'b1, WK + 100, n);
    chk(32'(n >= WK && n <= WK + 12), 32'h1);
    chk(inputs_ok, 1'b1);
    chk(bridge_enable, 1'b1);
    axi_read(REG_STATUS, exp_status(1'b1, 1'b1, ST_ACTIVE), RESP_OKAY);
    // supply lockout and automatic recovery
    sup_lo <= 1'b1;
    wait_for(3, 1'b0, 20, n);
    repeat (2) @(posedge aclk);
    chk(bridge_enable, 1'b0);
    chk(charge_pump_enable, 1'b0);
    chk(device_ready, 1'b0);
    sup_lo <= 1'b0;
    wait_for(0, 1'b1, WK + 100, n);
    chk(fault_n, 1'b1);
    // pump rail undervoltage keeps the pump running
    pump_uv <= 1'b1;
    wait_for(1, 1'b0, 20, n);
    repeat (2) @(posedge aclk);
    chk(fault_n, 1'b0);
    chk(charge_pump_enable, 1'b1);
    pump_uv <= 1'b0;
    wait_for(1, 1'b1, 20, n);
    chk(fault_n, 1'b1);
    // short current-limit glitches must be filtered out
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      prot <= lfsr_q[5:3];
      ovc <= 1'b1;
      repeat (1 + int'(lfsr_q[2:0])) @(posedge aclk);
      ovc <= 1'b0;
      repeat (20) @(posedge aclk);
      chk(fault_n, 1'b1);
    end
    // overcurrent latches until a clearing pulse of random legal width
    for (int i = 0; i < 3; i++) begin
      ovc <= 1'b1;
      wait_for(3, 1'b0, 30, n);
      chk(bridge_enable, 1'b0);
      chk(charge_pump_enable, 1'b1);
      ovc <= 1'b0;
      repeat (100) @(posedge aclk);
      chk(fault_n, 1'b0);
      lfsr_q = lfsr_next(lfsr_q);
      clear_pulse(60 + int'(lfsr_q) % 8900, held);
      chk(held, 1'b1);
      chk(fault_n, 1'b1);
      chk(bridge_enable, 1'b1);
    end
    // thermal fault survives a pulse while hot
    hot <= 1'b1;
    wait_for(3, 1'b0, 20, n);
    repeat (2) @(posedge aclk);
    chk(bridge_enable, 1'b0);
    clear_pulse(100, held);
    chk(fault_n, 1'b0);
    hot <= 1'b0;
    repeat (50) @(posedge aclk);
    chk(fault_n, 1'b0);
    clear_pulse(100, held);
    wait_for(0, 1'b1, WK + 200, n);
    chk(fault_n, 1'b1);
    // register access, inhibit bit, read-only and unmapped places
    axi_write(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    wait_for(1, 1'b0, 10, n);
    axi_read(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    axi_write(REG_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    axi_write(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    wait_for(1, 1'b1, 10, n);
    axi_write(4'h8, 32'h0000_0000, RESP_SLVERR);
    axi_read(4'hC, 32'h0000_0000, RESP_SLVERR);
    ovc <= 1'b1;
    wait_for(3, 1'b0, 30, n);
    ovc <= 1'b0;
    axi_write(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    chk(fault_n, 1'b1);
    wstrb <= 4'hE;
    axi_write(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    // long low pin with a latched fault: cleared, then asleep
    ovc <= 1'b1;
    wait_for(3, 1'b0, 30, n);
    ovc <= 1'b0;
    run_req <= 1'b0;
    repeat (SL - 100) @(posedge aclk);
    chk(charge_pump_enable, 1'b1);
    chk(fault_n, 1'b1);
    wait_for(2, 1'b0, 200, n);
    chk(32'(n >= 96 && n <= 120), 32'h1);
    chk(device_ready, 1'b0);
    chk(bridge_enable, 1'b0);
    repeat (5000) @(posedge aclk);
    run_req <= 1'b1;
    wait_for(0, 1'b1, WK + 100, n);
    chk(fault_n, 1'b1);
    report_and_stop();
  end
endmodule
